// *** hdl/dsx_map.svh ***
`ifndef DSX_MAP_SVH
`define DSX_MAP_SVH
// Operation
// - decrement-skip-if-zero reads the addressed file register and subtracts one
// - destination bit 0 writes accumulator, 1 writes back to file register
// - zero result squashes the fetched next instruction, costing two cycles
// - access bit 0 uses access bank, 1 uses bank select register
// - extended set with access bit 0 indexes operands up to 95
// - extended set enables indexed offset for the decrement-skip instructions
// - extended set off: embedded address is a literal bank location
// - indexed mode adds operand to software stack pointer for address
// - software stack pointer of zero reproduces the original access bank mapping
// - push stores program counter plus two on return stack in one cycle
`define DSX_IDX_LIMIT      8'h5F
`define DSX_ACC_SPLIT      8'h60
`define DSX_HI_ACC_BANK    4'hF
`define DSX_PUSH_INC       21'h000002
`define DSX_OP_DSZ         6'h0B
`define DSX_OP_DSNZ        6'h13
`define DSX_OP_PUSH        16'h0005
`define DSX_OP_POP         16'h0006
`define DSX_STACK_DEPTH    31
`define DSX_SP_W           5
`define DSX_OPC_HI         15
`define DSX_OPC_LO         10
`define DSX_D_POS          9
`define DSX_A_POS          8
`define DSX_F_HI           7
`endif

// *** hdl/dsx_pkg.sv ***
package dsx_pkg;
  typedef enum logic [1:0] {
    DSX_EXEC = 2'b00,
    DSX_SKIP = 2'b01
  } dsx_state_e;
  typedef logic [11:0] dsx_addr_t;
  typedef logic [20:0] dsx_pc_t;
endpackage

// *** hdl/dsx_core.sv ***
`include "dsx_map.svh"
// instruction slice of the core: executes one instruction word per cycle.
// the data memory itself lives outside; this block forms the effective
// address, takes the read data, and issues the write.
module dsx_core
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr,
  input  wire dsx_pkg::dsx_pc_t  pc,
  input  wire logic              ext_set_en,
  input  wire logic [3:0]        bank_select_register,
  input  wire logic [11:0]       software_stack_pointer,
  input  wire logic [7:0]        file_rdata,
  output logic [11:0]            file_addr,
  output logic                   file_we,
  output logic [7:0]             file_wdata,
  output logic                   wreg_we,
  output logic [7:0]             wreg_data,
  output logic                   squash,
  output dsx_pkg::dsx_pc_t       return_stack_top,
  output logic [4:0]             stack_level,
  output logic                   stack_over,
  output logic                   stack_under
);

  // ****************************************************
  // reset synchroniser
  // ****************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************
  // decode and address formation
  // ****************************************************
  function automatic logic [11:0] eff_addr(
    input logic [7:0]  f,
    input logic        a,
    input logic        ext,
    input logic [3:0]  bank,
    input logic [11:0] fsp
  );
    logic [11:0] r;
    r = {bank, f};
    if (!a)
    begin
      if (ext && f <= `DSX_IDX_LIMIT)
        r = fsp + {4'h0, f};
      else if (f < `DSX_ACC_SPLIT)
        r = {4'h0, f};
      else
        r = {`DSX_HI_ACC_BANK, f};
    end
    return r;
  endfunction

  dsx_pkg::dsx_state_e state;
  dsx_pkg::dsx_state_e next_state;

  wire [5:0] opcode   = instr[`DSX_OPC_HI:`DSX_OPC_LO];
  wire [7:0] fop      = instr[`DSX_F_HI:0];
  wire       live     = instr_valid && (state == dsx_pkg::DSX_EXEC);
  wire       is_dsz   = live && (opcode == `DSX_OP_DSZ);
  wire       is_dsnz  = live && (opcode == `DSX_OP_DSNZ);
  wire       is_dec   = is_dsz || is_dsnz;
  wire       is_push  = live && (instr == `DSX_OP_PUSH);
  wire       is_pop   = live && (instr == `DSX_OP_POP);
  wire       dbit     = instr[`DSX_D_POS];
  wire       abit     = instr[`DSX_A_POS];
  wire [7:0] dec_res  = file_rdata - 8'h01;
  wire       res_zero = (dec_res == 8'h00);
  wire       do_skip  = (is_dsz && res_zero) || (is_dsnz && !res_zero);
  wire [11:0] addr_now = eff_addr(fop, abit, ext_set_en,
                                  bank_select_register,
                                  software_stack_pointer);

  assign next_state = do_skip ? dsx_pkg::DSX_SKIP : dsx_pkg::DSX_EXEC;

  sequence s_dsz_zero;
    is_dsz && res_zero;
  endsequence

  sequence s_dsnz_nonzero;
    is_dsnz && !res_zero;
  endsequence

  // a skip is one squash pulse, after which the core takes words again
  sequence s_skip_slot;
    (squash && state == dsx_pkg::DSX_SKIP)
    ##1 (!squash && state == dsx_pkg::DSX_EXEC);
  endsequence

  AST_SKIP_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_dsz_zero |=> s_skip_slot)
    else $error("zero result did not squash");

  AST_SKIP_NZ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_dsnz_nonzero |=> s_skip_slot)
    else $error("nonzero result did not squash");

  AST_NO_SKIP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_dsz && !res_zero |=> !squash)
    else $error("spurious squash");

  AST_NO_SKIP_NZ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_dsnz && res_zero |=> !squash)
    else $error("spurious squash on zero result");

  AST_SKIP_ONE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    squash |=> !squash)
    else $error("skip lasted more than one cycle");

  AST_SQUASH_SRC: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    squash |-> $past(is_dec))
    else $error("squash without a decrement");

  AST_SKIP_DROP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == dsx_pkg::DSX_SKIP
    |=> !file_we && !wreg_we && !squash && $stable(stack_level))
    else $error("discarded instruction took effect");

  AST_INDEX: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    live && ext_set_en && !abit && fop <= `DSX_IDX_LIMIT
    |=> file_addr == $past(software_stack_pointer) + {4'h0, $past(fop)})
    else $error("indexed address wrong");

  AST_BANKED: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    live && abit
    |=> file_addr == {$past(bank_select_register), $past(fop)})
    else $error("banked address wrong");

  AST_ACCESS_LO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    live && !ext_set_en && !abit && fop < `DSX_ACC_SPLIT
    |=> file_addr == {4'h0, $past(fop)})
    else $error("low access bank address wrong");

  AST_ACCESS_HI: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    live && !abit && fop >= `DSX_ACC_SPLIT
    |=> file_addr == {`DSX_HI_ACC_BANK, $past(fop)})
    else $error("high access bank address wrong");

  AST_COMPAT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    live && ext_set_en && !abit && fop <= `DSX_IDX_LIMIT
    && software_stack_pointer == 12'h000
    |=> file_addr == {4'h0, $past(fop)})
    else $error("zero pointer does not map like the access bank");

  // ****************************************************
  // return stack
  // ****************************************************
  dsx_pkg::dsx_pc_t stk [`DSX_STACK_DEPTH];
  logic [4:0] sp;
  wire  stk_full  = (sp == 5'(`DSX_STACK_DEPTH));
  wire  stk_empty = (sp == 5'h00);
  wire  [4:0] next_sp = is_push && !stk_full ? sp + 5'h01 :
                        is_pop && !stk_empty ? sp - 5'h01 : sp;
  wire  dsx_pkg::dsx_pc_t pc_ret = pc + `DSX_PUSH_INC;
  wire  [4:0] top_idx = next_sp - 5'h01;

  // overflow and underflow are dropped rather than wrapped so the
  // existing entries survive a runaway push or pop
  always_ff @(posedge ref_clk)
  begin
    if (is_push && !stk_full)
      stk[sp] <= pc_ret;
  end

  // ****************************************************
  // state and outputs
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= dsx_pkg::DSX_EXEC;
      sp          <= 5'h00;
      stack_over  <= 1'b0;
      stack_under <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      sp          <= next_sp;
      stack_over  <= is_push && stk_full;
      stack_under <= is_pop && stk_empty;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_addr  <= 12'h000;
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
      wreg_we    <= 1'b0;
      wreg_data  <= 8'h00;
      squash     <= 1'b0;
      stack_level <= 5'h00;
    end
    else
    begin
      file_addr  <= addr_now;
      file_we    <= is_dec && dbit;
      file_wdata <= dec_res;
      wreg_we    <= is_dec && !dbit;
      wreg_data  <= dec_res;
      squash     <= do_skip;
      stack_level <= next_sp;
    end
  end

  AST_DEST: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_dec |=> file_we == $past(dbit) && wreg_we != file_we)
    else $error("destination select wrong");

  AST_DEC: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_dec |=> wreg_data == $past(file_rdata) - 8'h01
               && file_wdata == $past(file_rdata) - 8'h01)
    else $error("result is not operand minus one");

  AST_NO_WRITE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !is_dec |=> !file_we && !wreg_we)
    else $error("write without a decrement");

  // top of stack is registered from the written value on a push and from
  // the entry below on a pop (zero once empty), to keep outputs straight from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      return_stack_top <= 21'h000000;
    else if (is_push && !stk_full)
      return_stack_top <= pc_ret;
    else if (is_pop && !stk_empty)
      return_stack_top <= (next_sp == 5'h00) ? 21'h000000 : stk[top_idx];
  end

  // ****************************************************
  // stack checks
  // ****************************************************

  AST_PUSH: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_push && !stk_full
    |=> return_stack_top == $past(pc) + 21'h000002
        && stack_level == $past(sp) + 5'h01)
    else $error("push result wrong");

  AST_POP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_pop && !stk_empty |=> stack_level == $past(sp) - 5'h01)
    else $error("pop did not drop one level");

  AST_POP_LAST: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_pop && sp == 5'h01 |=> return_stack_top == 21'h000000)
    else $error("emptied stack shows a stale top");

  AST_OVER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_push && stk_full
    |=> stack_over && $stable(stack_level) && $stable(return_stack_top))
    else $error("push on a full stack was not refused");

  AST_UNDER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    is_pop && stk_empty |=> stack_under && stack_level == 5'h00)
    else $error("pop on an empty stack was not refused");

  AST_FLAG_SRC: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    stack_over || stack_under |-> $past(is_push) || $past(is_pop))
    else $error("stack flag without a push or pop");

endmodule // dsx_core

// *** test/tb.sv ***
`include "dsx_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             ref_clk = 1'b0;
  logic             resetn = 1'b0;
  logic             instr_valid = 1'b0;
  logic [15:0]      instr = 16'h0000;
  dsx_pkg::dsx_pc_t pc = 21'h000000;
  logic             ext_set_en = 1'b0;
  logic [3:0]       bank_select_register = 4'h0;
  logic [11:0]      software_stack_pointer = 12'h000;
  logic [7:0]       file_rdata = 8'h00;
  logic [11:0]      file_addr;
  logic             file_we, wreg_we, squash, stack_over, stack_under;
  logic [7:0]       file_wdata, wreg_data;
  dsx_pkg::dsx_pc_t return_stack_top;
  logic [4:0]       stack_level;
  int               miscompares = 0;
  int               cmp_count = 0;
  dsx_core u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .instr_valid(instr_valid), .instr(instr), .pc(pc),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .software_stack_pointer(software_stack_pointer),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .wreg_we(wreg_we), .wreg_data(wreg_data),
    .squash(squash), .return_stack_top(return_stack_top),
    .stack_level(stack_level), .stack_over(stack_over),
    .stack_under(stack_under));
  initial forever #12.5 ref_clk = ~ref_clk;
  // ***************************************
  // shared tasks
  // ***************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one instruction, then an idle cycle so it is not taken twice
  task automatic go(input logic [15:0] i, input logic [7:0] rd,
                    input logic e, input logic [3:0] bk,
                    input logic [11:0] sp, input dsx_pkg::dsx_pc_t p);
    @(posedge ref_clk);
    instr <= i; file_rdata <= rd; ext_set_en <= e; pc <= p;
    bank_select_register <= bk; software_stack_pointer <= sp;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_dec;
    logic [7:0]  tf [7] = '{8'h10, 8'h80, 8'h22, 8'h5F, 8'h60, 8'h10, 8'h10};
    logic        ta [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic        te [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0]  rd;
    logic [3:0]  bk;
    logic [11:0] sp, ea;
    logic        sq;
    for (int op = 0; op < 2; op++)
      for (int d = 0; d < 2; d++)
        for (int k = 0; k < 7; k++)
        begin
          rd = (k % 3 == 0) ? 8'h01 : ((k % 3 == 1) ? 8'h00 : 8'h37);
          bk = 4'h3 + k[3:0];
          sp = (k == 5) ? 12'h000 : 12'h200;
          if (!ta[k] && te[k] && tf[k] <= 8'h5F) ea = sp + {4'h0, tf[k]};
          else if (ta[k]) ea = {bk, tf[k]};
          else if (tf[k] < 8'h60) ea = {4'h0, tf[k]};
          else ea = {4'hF, tf[k]};
          sq = (op == 0) ? (rd == 8'h01) : (rd != 8'h01);
          go({(op == 0) ? `DSX_OP_DSZ : `DSX_OP_DSNZ, d[0], ta[k], tf[k]},
             rd, te[k], bk, sp, 21'h000100);
          chk(file_addr, ea);
          chk(file_we, d[0]);
          chk(wreg_we, !d[0]);
          chk(d[0] ? file_wdata : wreg_data, 8'(rd - 8'h01));
          chk(squash, sq);
        end
  endtask
  task automatic t_skip;
    @(posedge ref_clk);
    instr <= {`DSX_OP_DSZ, 2'b10, 8'h20}; file_rdata <= 8'h01;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr <= `DSX_OP_PUSH;
    #1 chk(squash, 1'b1);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk(stack_level, 5'h00);
    chk(squash, 1'b0);
  endtask
  task automatic t_stack;
    go(`DSX_OP_PUSH, 8'h00, 1'b0, 4'h0, 12'h000, 21'h001000);
    chk(return_stack_top, 21'h001002);
    go(`DSX_OP_PUSH, 8'h00, 1'b0, 4'h0, 12'h000, 21'h1FFFFF);
    chk(return_stack_top, 21'h000001);
    chk(stack_level, 5'h02);
    go(`DSX_OP_POP, 8'h00, 1'b0, 4'h0, 12'h000, 21'h000000);
    chk(return_stack_top, 21'h001002);
    chk(stack_level, 5'h01);
    go(`DSX_OP_POP, 8'h00, 1'b0, 4'h0, 12'h000, 21'h000000);
    go(`DSX_OP_POP, 8'h00, 1'b0, 4'h0, 12'h000, 21'h000000);
    chk(stack_under, 1'b1);
    chk(stack_level, 5'h00);
    for (int n = 0; n < 32; n++)
      go(`DSX_OP_PUSH, 8'h00, 1'b0, 4'h0, 12'h000, n[20:0]);
    chk(stack_over, 1'b1);
    chk(stack_level, 5'h1F);
    chk(return_stack_top, 21'h000020);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_dec();
    t_skip();
    t_stack();
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
endmodule // tb
